// *** verilog/sspi_core.sv ***
// Synchronous serial port I2C slave core with stretching and collision check
`timescale 1ns/100ps
`include "sspi_consts.svh"
module sspi_core (
	input  wire logic       mclk_in,
	input  wire logic       rst_in,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	input  wire logic       i2c_mode_in,
	input  wire logic       port_enable_bit_in,
	input  wire logic       long_hold_select_in,
	input  wire logic [6:0] own_address_in,
	input  wire logic [7:0] tx_data_in,
	input  wire logic       tx_load_in,
	input  wire logic       ev_clear_in,
	input  wire logic       col_clear_in,
	output logic            scl_out,
	output logic            scl_oe_out,
	output logic            sda_out,
	output logic            sda_oe_out,
	output logic [7:0]      rx_data_out,
	output logic            rx_valid_out,
	output logic            write_req_out,
	output logic            read_req_out,
	output logic            addressed_out,
	output logic            tx_full_out,
	output logic            ev_flag_out,
	output logic            col_flag_out,
	output logic            bus_idle_out
);
	localparam logic [`SSPI_HOLD_W-1:0] HOLD_S = `SSPI_HOLD_W'(`SSPI_HOLD_SHORT_CYC);
	localparam logic [`SSPI_HOLD_W-1:0] HOLD_L = `SSPI_HOLD_W'(`SSPI_HOLD_LONG_CYC);

	// Refuse a hold count that the hold counter cannot reach
	if (`SSPI_HOLD_LONG_CYC >= (1 << `SSPI_HOLD_W)) begin : g_hold_check
		$error("hold counter too narrow for the long hold");
	end

	sspi_pkg::sspi_state_s r_reg;
	sspi_pkg::sspi_state_s r_next;

	logic                    en;
	logic                    rise;
	logic                    fall;
	logic                    start;
	logic                    stop;
	logic                    collide;
	logic [`SSPI_HOLD_W-1:0] hold_cyc;

	// Bus edges and conditions from the synchronised pins
	assign en       = i2c_mode_in & port_enable_bit_in;
	assign rise     = r_reg.scl_s & ~r_reg.scl_p;
	assign fall     = ~r_reg.scl_s & r_reg.scl_p;
	assign start    = r_reg.scl_s & r_reg.scl_p & r_reg.sda_p & ~r_reg.sda_s;
	assign stop     = r_reg.scl_s & r_reg.scl_p & ~r_reg.sda_p & r_reg.sda_s;
	assign hold_cyc = long_hold_select_in ? HOLD_L : HOLD_S;
	assign collide  = rise && r_reg.state == sspi_pkg::ST_TX && r_reg.cnt < `SSPI_ACK_CNT
		&& !r_reg.sda_oe && !r_reg.sda_s;

	// Next state of the whole core
	always_comb begin
		logic ev_set;
		ev_set = 1'b0;
		r_next = r_reg;
		r_next.scl_m = scl_in;
		r_next.scl_s = r_reg.scl_m;
		r_next.scl_p = r_reg.scl_s;
		r_next.sda_m = sda_in;
		r_next.sda_s = r_reg.sda_m;
		r_next.sda_p = r_reg.sda_s;
		r_next.rx_valid = 1'b0;
		r_next.pin_o = 1'b0;
		// Delayed data change keeps SDA valid after the clock falls
		if (r_reg.hold != '0) begin
			r_next.hold = r_reg.hold - 1'b1;
			if (r_reg.hold == `SSPI_HOLD_W'(1))
				r_next.sda_oe = r_reg.pend;
		end
		// Hold SCL low until a byte to send is present
		if (r_reg.scl_oe) begin
			if (!r_reg.loaded && r_reg.tx_full && r_reg.hold == '0) begin
				r_next.sh = r_reg.tx_buf;
				r_next.sda_oe = ~r_reg.tx_buf[7];
				r_next.loaded = 1'b1;
				r_next.tx_full = 1'b0;
			end else if (r_reg.loaded) begin
				r_next.scl_oe = 1'b0;
			end
		end
		if (!en) begin
			r_next.state = sspi_pkg::ST_IDLE;
			r_next.sda_oe = 1'b0;
			r_next.scl_oe = 1'b0;
			r_next.hold = '0;
			r_next.cnt = '0;
			r_next.idle = 1'b1;
		end else if (start) begin
			r_next.state = sspi_pkg::ST_ADDR;
			r_next.cnt = '0;
			r_next.sda_oe = 1'b0;
			r_next.scl_oe = 1'b0;
			r_next.hold = '0;
			r_next.idle = 1'b0;
			r_next.write_req = 1'b0;
			r_next.read_req = 1'b0;
		end else if (stop) begin
			r_next.state = sspi_pkg::ST_IDLE;
			r_next.sda_oe = 1'b0;
			r_next.scl_oe = 1'b0;
			r_next.hold = '0;
			r_next.idle = 1'b1;
			r_next.write_req = 1'b0;
			r_next.read_req = 1'b0;
		end else if (collide) begin
			r_next.state = sspi_pkg::ST_WAIT;
			r_next.sda_oe = 1'b0;
			r_next.hold = '0;
		end else if (rise && r_reg.state != sspi_pkg::ST_IDLE
				&& r_reg.state != sspi_pkg::ST_WAIT) begin
			r_next.cnt = r_reg.cnt + 1'b1;
			if (r_reg.cnt < `SSPI_ACK_CNT) begin
				if (r_reg.state != sspi_pkg::ST_TX)
					r_next.sh = {r_reg.sh[6:0], r_reg.sda_s};
			end else begin
				r_next.mack = ~r_reg.sda_s;
			end
		end else if (fall && r_reg.state != sspi_pkg::ST_IDLE
				&& r_reg.state != sspi_pkg::ST_WAIT) begin
			r_next.hold = hold_cyc;
			if (r_reg.cnt == `SSPI_ACK_CNT) begin
				case (r_reg.state)
					sspi_pkg::ST_ADDR: begin
						if (r_reg.sh[7:1] == own_address_in) begin
							r_next.rw = r_reg.sh[0];
							r_next.write_req = ~r_reg.sh[0];
							r_next.read_req = r_reg.sh[0];
							r_next.pend = 1'b1;
							ev_set = 1'b1;
						end else begin
							r_next.state = sspi_pkg::ST_WAIT;
							r_next.pend = 1'b0;
						end
					end
					sspi_pkg::ST_RX: begin
						r_next.rx_data = r_reg.sh;
						r_next.rx_valid = 1'b1;
						r_next.pend = 1'b1;
						ev_set = 1'b1;
					end
					default: r_next.pend = 1'b0;
				endcase
			end else if (r_reg.cnt == `SSPI_LAST_CNT) begin
				r_next.cnt = '0;
				r_next.pend = 1'b0;
				case (r_reg.state)
					sspi_pkg::ST_ADDR: begin
						r_next.state = r_reg.rw ? sspi_pkg::ST_TX : sspi_pkg::ST_RX;
						r_next.scl_oe = r_reg.rw;
						r_next.loaded = 1'b0;
					end
					sspi_pkg::ST_TX: begin
						if (r_reg.mack) begin
							r_next.scl_oe = 1'b1;
							r_next.loaded = 1'b0;
							ev_set = 1'b1;
						end else begin
							r_next.state = sspi_pkg::ST_WAIT;
						end
					end
					default: r_next.state = r_reg.state;
				endcase
			end else if (r_reg.state == sspi_pkg::ST_TX) begin
				r_next.sh = {r_reg.sh[6:0], 1'b0};
				r_next.pend = ~r_reg.sh[6];
			end else begin
				r_next.hold = '0;
			end
		end
		// Software load of the next byte, set wins over consume
		if (tx_load_in) begin
			r_next.tx_full = 1'b1;
			r_next.tx_buf = tx_data_in;
		end
		r_next.ev_flag = (r_reg.ev_flag & ~ev_clear_in) | ev_set;
		r_next.col_flag = (r_reg.col_flag & ~col_clear_in) | (en & collide);
		r_next.addressed = r_next.state == sspi_pkg::ST_RX
			|| r_next.state == sspi_pkg::ST_TX;
		r_next.bus_free = r_next.idle & r_reg.scl_s & r_reg.sda_s;
	end

	// State register
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			r_reg <= '0;
			r_reg.state <= sspi_pkg::ST_IDLE;
			r_reg.idle <= 1'b1;
			r_reg.scl_m <= 1'b1; // Idle line level, so no false edge follows reset
			r_reg.scl_s <= 1'b1;
			r_reg.scl_p <= 1'b1;
			r_reg.sda_m <= 1'b1;
			r_reg.sda_s <= 1'b1;
			r_reg.sda_p <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	// Outputs straight from the state register
	assign scl_out       = r_reg.pin_o;
	assign scl_oe_out    = r_reg.scl_oe;
	assign sda_out       = r_reg.pin_o;
	assign sda_oe_out    = r_reg.sda_oe;
	assign rx_data_out   = r_reg.rx_data;
	assign rx_valid_out  = r_reg.rx_valid;
	assign write_req_out = r_reg.write_req;
	assign read_req_out  = r_reg.read_req;
	assign addressed_out = r_reg.addressed;
	assign tx_full_out   = r_reg.tx_full;
	assign ev_flag_out   = r_reg.ev_flag;
	assign col_flag_out  = r_reg.col_flag;
	assign bus_idle_out  = r_reg.bus_free;

	// Checks on the core behaviour
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	a_pin_data_zero: assert property (sda_out == 1'b0 && scl_out == 1'b0)
		else $error("pin output data not zero");
	a_open_drain_off: assert property (!en |=> !sda_oe_out && !scl_oe_out)
		else $error("pin driven while port disabled");
	a_hold_short: assert property (en && fall && !long_hold_select_in && !start && !stop
		&& r_reg.state == sspi_pkg::ST_TX |=> $stable(sda_oe_out)[*8])
		else $error("SDA changed inside short hold");
	a_collision_flag: assert property (en && collide |=> col_flag_out && !sda_oe_out)
		else $error("collision not flagged");
	a_flag_set_wins: assert property (en && collide && col_clear_in |=> col_flag_out)
		else $error("collision flag lost on clear");
	a_start_addr: assert property (en && start |=> r_reg.state == sspi_pkg::ST_ADDR)
		else $error("start not taken");
	a_stop_idle: assert property (en && stop |=> !addressed_out ##2 1'b1)
		else $error("stop not taken");
	a_ack_release: assert property (en && fall && r_reg.state == sspi_pkg::ST_TX
		&& r_reg.cnt == `SSPI_ACK_CNT && !start && !stop |-> ##[1:40] !sda_oe_out)
		else $error("SDA not released for acknowledge");
	a_addr_match: assert property (en && fall && r_reg.state == sspi_pkg::ST_ADDR
		&& r_reg.cnt == `SSPI_ACK_CNT && r_reg.sh[7:1] == own_address_in && !start && !stop
		|=> write_req_out == ~$past(r_reg.sh[0]) && read_req_out == $past(r_reg.sh[0]))
		else $error("address match not reported");
	a_stretch_cause: assert property ($rose(scl_oe_out) |-> $past(fall))
		else $error("SCL pulled low without a falling edge");

	// Further checks on framing, flags and stretching
	// Receive strobe is a single cycle wide
	a_rx_pulse_one: assert property (rx_valid_out |=> !rx_valid_out)
		else $error("receive strobe longer than one cycle");
	// A received byte is handed over whole at the eighth fall
	a_rx_byte_out: assert property (en && fall && r_reg.state == sspi_pkg::ST_RX
		&& r_reg.cnt == `SSPI_ACK_CNT && !start && !stop
		|=> rx_valid_out && rx_data_out == $past(r_reg.sh))
		else $error("received byte not handed over");
	// Bit counter never passes the acknowledge slot
	a_bit_count_max: assert property (r_reg.cnt <= `SSPI_LAST_CNT)
		else $error("bit counter out of range");
	// Software load always shows as a full buffer
	a_tx_load_full: assert property (tx_load_in |=> tx_full_out)
		else $error("loaded byte not flagged");
	// Clearing without a new collision empties the flag
	a_col_clear: assert property (col_clear_in && !(en && collide) |=> !col_flag_out)
		else $error("collision flag not cleared");
	// Nothing drives SDA while the core is idle
	a_idle_no_drive: assert property (r_reg.state == sspi_pkg::ST_IDLE
		&& r_reg.hold == '0 |-> !sda_oe_out)
		else $error("SDA driven while idle");
	// An idle bus has no addressed transfer
	a_idle_not_addr: assert property (bus_idle_out |-> !addressed_out)
		else $error("addressed while bus idle");
	// A stretch ends the cycle after the byte is loaded
	a_scl_release: assert property (scl_oe_out && r_reg.loaded |=> !scl_oe_out)
		else $error("SCL held after byte loaded");
	// Matching address is acknowledged within 40 cycles of the clock fall
	a_ack_drive: assert property (en && fall && r_reg.state == sspi_pkg::ST_ADDR
		&& r_reg.cnt == `SSPI_ACK_CNT && r_reg.sh[7:1] == own_address_in && !start && !stop
		|-> ##[1:40] sda_oe_out)
		else $error("matching address not acknowledged");
	// Read address stretches SCL; write address enters receive
	a_read_stretch: assert property (en && fall && r_reg.state == sspi_pkg::ST_ADDR
		&& r_reg.cnt == `SSPI_LAST_CNT && !start && !stop
		|=> scl_oe_out == $past(r_reg.rw))
		else $error("read address did not stretch SCL");
	a_write_enter: assert property (en && fall && r_reg.state == sspi_pkg::ST_ADDR
		&& r_reg.cnt == `SSPI_LAST_CNT && !r_reg.rw && !start && !stop
		|=> r_reg.state == sspi_pkg::ST_RX)
		else $error("write address did not enter receive");
	// Master not acknowledging ends the read
	a_nack_wait: assert property (en && fall && r_reg.state == sspi_pkg::ST_TX
		&& r_reg.cnt == `SSPI_LAST_CNT && !r_reg.mack && !start && !stop
		|=> r_reg.state == sspi_pkg::ST_WAIT)
		else $error("read not ended on missing acknowledge");
	// Long hold keeps SDA steady well past the clock fall
	a_hold_long: assert property (en && fall && long_hold_select_in && !start && !stop
		&& r_reg.state == sspi_pkg::ST_TX
		|=> $stable(sda_oe_out)[*8] ##1 $stable(sda_oe_out)[*8] ##1 $stable(sda_oe_out)[*8])
		else $error("SDA changed inside long hold");
	// A stop lets go of both lines at once
	a_stop_release: assert property (en && stop |=> !sda_oe_out && !scl_oe_out)
		else $error("lines held after stop");
endmodule

// *** verilog/sspi_consts.svh ***
// Constants for the synchronous serial port I2C slave core
// What this block does
// - Bytes shift onto the data line most significant bit first.
// - Software reaches six register groups; two sticky event flags report activity.
// - Each bus unit is eight data bits plus one acknowledge bit.
// - After the eighth falling edge the data sender releases SDA for acknowledge.
// - Only the master makes clock pulses; a slave never originates them.
// - SDA changes only while SCL is low; receivers sample on SCL rising.
// - SDA changing while SCL is high is a bus condition, not data.
// - With I2C mode and port enable, both pins are open-drain.
// - Pin output data is fixed at zero; lines rise only by release.
// - Long hold select keeps SDA valid 300 ns after SCL falls.
// - A master starts, clocks and ends transfers; slaves are addressed.
// - Arbitration leaves one master in control, its message uncorrupted.
// - Masters synchronise their clocks through the shared clock line.
// - Bus is idle when no master controls it and both lines high.
// - Slave recognises its address when it equals the own address value.
// - Matching address with read/write clear is a write request.
// - Read request: slave supplies bytes until the master withholds acknowledge, or until repeated start or stop.
// - Any device may hold SCL low; others wait for its release.
// - Flag a bus collision when SDA reads low while driving high.
`ifndef SSPI_CONSTS_SVH
`define SSPI_CONSTS_SVH
`define SSPI_CLK_NS        10
`define SSPI_HOLD_SHORT_NS 100
`define SSPI_HOLD_LONG_NS  300
`define SSPI_HOLD_W        5
`define SSPI_HOLD_SHORT_CYC ((`SSPI_HOLD_SHORT_NS + `SSPI_CLK_NS - 1) / `SSPI_CLK_NS)
`define SSPI_HOLD_LONG_CYC  ((`SSPI_HOLD_LONG_NS + `SSPI_CLK_NS - 1) / `SSPI_CLK_NS)
`define SSPI_ACK_CNT       4'h8
`define SSPI_LAST_CNT      4'h9
`endif

// *** verilog/sspi_pkg.sv ***
// Types for the synchronous serial port I2C slave core
`include "sspi_consts.svh"
package sspi_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_RX, ST_TX, ST_WAIT} sspi_state_e;
	typedef struct packed {
		sspi_state_e             state;
		logic                    scl_m, scl_s, scl_p;
		logic                    sda_m, sda_s, sda_p;
		logic [3:0]              cnt;
		logic [7:0]              sh;
		logic                    rw, mack;
		logic [`SSPI_HOLD_W-1:0] hold;
		logic                    pend, sda_oe, scl_oe, loaded;
		logic                    tx_full;
		logic [7:0]              tx_buf, rx_data;
		logic                    rx_valid, write_req, read_req, addressed;
		logic                    ev_flag, col_flag, idle, bus_free, pin_o;
	} sspi_state_s;
endpackage

// *** sim/sspi_master_model.sv ***
// Bus master model that clocks the slave core over the two open-drain lines
`timescale 1ns/100ps
module sspi_master_model (
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      scl_low_out,
	output logic      sda_low_out
);
	localparam realtime HALF = 62.5;
	// Both lines released until a frame begins
	initial begin
		scl_low_out = 1'b0;
		sda_low_out = 1'b0;
	end
	// One clock pulse: data set while SCL is low, sampled after the rise
	task automatic bit_io(input logic v, output logic s);
		scl_low_out = 1'b1;
		#(HALF);
		sda_low_out = ~v;
		#(5 * HALF);
		scl_low_out = 1'b0;
		wait (scl_in === 1'b1);
		#(HALF);
		s = sda_in;
		#(HALF);
	endtask
	// Start or repeated start: SDA falls while SCL is high
	task automatic start_cond();
		sda_low_out = 1'b0;
		#(HALF);
		scl_low_out = 1'b0;
		#(2 * HALF);
		sda_low_out = 1'b1;
		#(2 * HALF);
	endtask
	// Stop: SDA rises while SCL is high
	task automatic stop_cond();
		scl_low_out = 1'b1;
		#(HALF);
		sda_low_out = 1'b1;
		#(5 * HALF);
		scl_low_out = 1'b0;
		#(2 * HALF);
		sda_low_out = 1'b0;
		#(2 * HALF);
	endtask
	// Eight data bits then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic a_in, output logic [7:0] rx,
			output logic a);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(a_in, a);
	endtask
endmodule

// *** sim/sspi_core_tb_top.sv ***
// Testbench for the I2C slave core driven by a bus master model
`timescale 1ns/100ps
module sspi_core_tb_top;
	logic       mclk_in, rst_in, i2c_mode_in, port_enable_bit_in, long_hold_select_in;
	logic [6:0] own_address_in;
	logic [7:0] tx_data_in, rx_data_out, last_rx, rb;
	logic       tx_load_in, ev_clear_in, col_clear_in, scl_out, scl_oe_out, sda_out;
	logic       sda_oe_out, rx_valid_out, write_req_out, read_req_out, addressed_out;
	logic       tx_full_out, ev_flag_out, col_flag_out, bus_idle_out, m_scl, m_sda, ack;
	wire        scl = ~(m_scl | scl_oe_out);
	wire        sda = ~(m_sda | sda_oe_out);
	int         n_fail = 0, n_checks = 0, cyc = 0;
	realtime    t_fall = 0, t0;
	sspi_core DUT (.mclk_in, .rst_in, .scl_in(scl), .sda_in(sda), .i2c_mode_in,
		.port_enable_bit_in, .long_hold_select_in, .own_address_in, .tx_data_in,
		.tx_load_in, .ev_clear_in, .col_clear_in, .scl_out, .scl_oe_out, .sda_out,
		.sda_oe_out, .rx_data_out, .rx_valid_out, .write_req_out, .read_req_out,
		.addressed_out, .tx_full_out, .ev_flag_out, .col_flag_out, .bus_idle_out);
	sspi_master_model M (.scl_in(scl), .sda_in(sda), .scl_low_out(m_scl), .sda_low_out(m_sda));
	// Comparisons of single flags and of bytes
	task automatic chk1(input string n, input logic e, input logic s);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %b seen %b", n, e, s);
		end
	endtask
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
		n_checks++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// One-cycle software strobe
	task automatic strobe(ref logic s);
		@(negedge mclk_in) s = 1'b1;
		@(negedge mclk_in) s = 1'b0;
	endtask
	// Start plus address byte
	task automatic frame(input logic [7:0] a);
		M.start_cond();
		M.xfer(a, 1'b1, rb, ack);
		@(negedge mclk_in);
	endtask
	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end
	// Captures received bytes and cuts a hang short
	always @(posedge mclk_in) begin
		if (rx_valid_out === 1'b1) last_rx <= rx_data_out;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			stop_test();
		end
	end
	// Every SDA drive change must keep the selected hold after SCL falls
	always @(negedge scl) t_fall = $realtime;
	always @(sda_oe_out) if (!rst_in && t_fall > 0)
		chk1("hold", 1'b1, ($realtime - t_fall) >= (long_hold_select_in ? 300.0 : 100.0));
	initial begin
		{rst_in, i2c_mode_in, port_enable_bit_in, long_hold_select_in} = 4'he;
		{tx_load_in, ev_clear_in, col_clear_in} = 3'h0;
		own_address_in = 7'h5a;
		tx_data_in = 8'h3c;
		repeat (6) @(negedge mclk_in);
		rst_in = 1'b0;
		repeat (10) @(negedge mclk_in);
		chk1("idle", 1'b1, bus_idle_out);
		chk1("scl_out", 1'b0, scl_out);
		chk1("sda_oe", 1'b0, sda_oe_out);
		$display("reset test done");
		frame(8'hb4);
		chk1("addr ack", 1'b0, ack);
		chk1("write_req", 1'b1, write_req_out);
		chk1("busy", 1'b0, bus_idle_out);
		M.xfer(8'ha5, 1'b1, rb, ack);
		@(negedge mclk_in);
		chk1("data ack", 1'b0, ack);
		chk1("addressed", 1'b1, addressed_out);
		chk8("rx byte", 8'ha5, last_rx);
		chk1("event", 1'b1, ev_flag_out);
		strobe(ev_clear_in);
		chk1("event clr", 1'b0, ev_flag_out);
		M.stop_cond();
		repeat (10) @(negedge mclk_in);
		chk1("wr after stop", 1'b0, write_req_out);
		chk1("idle again", 1'b1, bus_idle_out);
		chk1("unaddressed", 1'b0, addressed_out);
		$display("write test done");
		long_hold_select_in = 1'b1;
		strobe(tx_load_in);
		chk1("tx_full", 1'b1, tx_full_out);
		frame(8'hb5);
		chk1("read_req", 1'b1, read_req_out);
		M.xfer(8'hff, 1'b0, rb, ack);
		@(negedge mclk_in);
		chk8("read 1", 8'h3c, rb);
		t0 = $realtime;
		fork
			M.xfer(8'hff, 1'b1, rb, ack);
			begin
				#3000 @(negedge mclk_in) tx_data_in = 8'hc3;
				strobe(tx_load_in);
			end
		join
		@(negedge mclk_in);
		chk8("read 2", 8'hc3, rb);
		chk1("stretch", 1'b1, ($realtime - t0) > 3000);
		M.stop_cond();
		$display("read test done");
		@(negedge mclk_in);
		long_hold_select_in = 1'b0;
		tx_data_in = 8'h0f;
		strobe(tx_load_in);
		frame(8'hb5);
		M.xfer(8'h07, 1'b1, rb, ack);
		@(negedge mclk_in);
		chk8("lost byte", 8'h07, rb);
		chk1("collision", 1'b1, col_flag_out);
		strobe(col_clear_in);
		chk1("col clr", 1'b0, col_flag_out);
		M.stop_cond();
		frame(8'h66);
		chk1("other addr", 1'b1, ack);
		chk1("no write", 1'b0, write_req_out);
		M.stop_cond();
		@(negedge mclk_in);
		i2c_mode_in = 1'b0;
		frame(8'hb4);
		chk1("disabled", 1'b1, ack);
		chk1("sda_out", 1'b0, sda_out);
		M.stop_cond();
		$display("error test done");
		stop_test();
	end
endmodule
